// ### core/pmurb_pkg.sv
// constants, types and register map of the channel readback block
package pmurb_pkg;

	// ==========================================================
	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned SEL_W = 2;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CH0_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CH1_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CH2_CFG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CH3_CFG = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_READ_SEL = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_READBACK = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h20;

	// ==========================================================
	// field positions in written words
	localparam int unsigned POS_CLR_TEMP = 6;
	localparam int unsigned POS_CFG_LO = 7;
	localparam int unsigned SYS_CL_LO = 0;
	localparam int unsigned SYS_CPO_LO = 4;
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_ONSET = 0;
	localparam int unsigned IRQ_CLEARED = 1;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		PMURB_FV_ICLAMP,
		PMURB_FI_VCLAMP,
		PMURB_HIZ_VOLT,
		PMURB_HIZ_CURR
	} pmurb_force_t;

	typedef enum logic [1:0] {
		PMURB_MEAS_ISENSE,
		PMURB_MEAS_VSENSE,
		PMURB_MEAS_TEMP,
		PMURB_MEAS_HIZ
	} pmurb_meas_t;

	// ==========================================================
	// per-channel settings, laid out as readback bits 21 down to 7
	typedef struct packed {
		logic channel_on;
		pmurb_force_t force_select;
		logic reserved_bit;
		logic [2:0] range_code;
		pmurb_meas_t measure_route;
		logic force_input_select;
		logic system_force_connect;
		logic system_sense_connect;
		logic current_limiter_on;
		logic comparator_output_on;
		logic compare_voltage;
	} pmurb_chan_t;

	localparam int unsigned CFG_W = $bits(pmurb_chan_t);

	// full 24-bit readback word
	typedef struct packed {
		logic [1:0] access_select;
		pmurb_chan_t chan;
		logic temp_alarm_sticky;
		logic temp_alarm_live;
		logic [4:0] unused_bits;
	} pmurb_word_t;

	localparam logic [1:0] ACCESS_CHANNEL = 2'h0;
	localparam logic [4:0] UNUSED_ZERO = 5'h00;

	// ==========================================================
	// reset values
	localparam pmurb_chan_t CHAN_RST = '0;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

endpackage

// ### core/pmurb_readback.sv
// channel configuration store, temperature alarm and 24-bit readback word
`timescale 1ns/10ps
module pmurb_readback (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// register port
	input wire logic [pmurb_pkg::ADDR_W-1:0] addr_i,
	input wire logic [pmurb_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [pmurb_pkg::DATA_W-1:0] rdata_o,
	// over-temperature sense and alarm pin
	input wire logic over_temp_i,
	output logic temp_alarm_pin_o,
	output logic temp_alarm_pin_oe_o,
	// interrupt
	output logic irq_o
);

	// ==========================================================
	// state
	typedef struct packed {
		pmurb_pkg::pmurb_chan_t [pmurb_pkg::NUM_CH-1:0] cfg;
		logic [pmurb_pkg::SEL_W-1:0] sel;
		logic temp_meta;
		logic temp_live;
		logic temp_sticky;
		logic [pmurb_pkg::IRQ_W-1:0] irq_stat;
		logic [pmurb_pkg::IRQ_W-1:0] irq_mask;
		logic [pmurb_pkg::DATA_W-1:0] rdata;
		logic irq;
		logic pin_oe;
	} pmurb_state_t;

	pmurb_state_t st_ff;
	pmurb_state_t nxt_st;
	pmurb_pkg::pmurb_word_t word;
	pmurb_pkg::pmurb_chan_t wr_cfg;
	logic [pmurb_pkg::IRQ_W-1:0] ev;
	logic live_next;

	// ==========================================================
	// readback word of the selected channel
	always_comb begin
		word = '0;
		word.access_select = pmurb_pkg::ACCESS_CHANNEL;
		word.chan = st_ff.cfg[st_ff.sel];
		word.chan.reserved_bit = 1'b0;
		word.temp_alarm_sticky = st_ff.temp_sticky;
		word.temp_alarm_live = st_ff.temp_live;
		word.unused_bits = pmurb_pkg::UNUSED_ZERO;
	end

	// ==========================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		wr_cfg = wdata_i[pmurb_pkg::POS_CFG_LO +: pmurb_pkg::CFG_W];
		wr_cfg.reserved_bit = 1'b0;
		// first synchroniser stage feeds both the second stage and the onset edge detect
		nxt_st.temp_meta = over_temp_i;
		nxt_st.temp_live = st_ff.temp_meta;
		live_next = st_ff.temp_meta;
		ev = '0;
		ev[pmurb_pkg::IRQ_ONSET] = live_next & ~st_ff.temp_live;
		ev[pmurb_pkg::IRQ_CLEARED] = 1'b0;

		// sticky flag: a live alarm keeps it set even during a clear
		if (wr_i && wdata_i[pmurb_pkg::POS_CLR_TEMP] && (addr_i == pmurb_pkg::OFS_CH0_CFG
				|| addr_i == pmurb_pkg::OFS_CH1_CFG || addr_i == pmurb_pkg::OFS_CH2_CFG
				|| addr_i == pmurb_pkg::OFS_CH3_CFG)) begin
			nxt_st.temp_sticky = 1'b0;
			ev[pmurb_pkg::IRQ_CLEARED] = st_ff.temp_sticky & ~st_ff.temp_live;
		end
		if (st_ff.temp_live) begin
			nxt_st.temp_sticky = 1'b1;
		end

		// register writes
		if (wr_i) begin
			unique case (addr_i)
				pmurb_pkg::OFS_CH0_CFG: begin
					nxt_st.cfg[0] = wr_cfg;
				end
				pmurb_pkg::OFS_CH1_CFG: begin
					nxt_st.cfg[1] = wr_cfg;
				end
				pmurb_pkg::OFS_CH2_CFG: begin
					nxt_st.cfg[2] = wr_cfg;
				end
				pmurb_pkg::OFS_CH3_CFG: begin
					nxt_st.cfg[3] = wr_cfg;
				end
				pmurb_pkg::OFS_SYS_CTRL: begin
					// system path overwrites the same bits, so the last writer wins
					for (int i = 0; i < pmurb_pkg::NUM_CH; i++) begin
						nxt_st.cfg[i].current_limiter_on =
							wdata_i[pmurb_pkg::SYS_CL_LO + i];
						nxt_st.cfg[i].comparator_output_on =
							wdata_i[pmurb_pkg::SYS_CPO_LO + i];
					end
				end
				pmurb_pkg::OFS_READ_SEL: begin
					nxt_st.sel = wdata_i[pmurb_pkg::SEL_W-1:0];
				end
				pmurb_pkg::OFS_IRQ_STAT: begin
					nxt_st.irq_stat = st_ff.irq_stat & ~wdata_i[pmurb_pkg::IRQ_W-1:0];
				end
				pmurb_pkg::OFS_IRQ_MASK: begin
					nxt_st.irq_mask = wdata_i[pmurb_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// set wins over a simultaneous clear
		nxt_st.irq_stat = nxt_st.irq_stat | ev;

		// register reads, data valid in the following cycle only
		nxt_st.rdata = pmurb_pkg::RD_ZERO;
		if (rd_i) begin
			unique case (addr_i)
				pmurb_pkg::OFS_CH0_CFG: begin
					nxt_st.rdata[pmurb_pkg::POS_CFG_LO +: pmurb_pkg::CFG_W] = st_ff.cfg[0];
				end
				pmurb_pkg::OFS_CH1_CFG: begin
					nxt_st.rdata[pmurb_pkg::POS_CFG_LO +: pmurb_pkg::CFG_W] = st_ff.cfg[1];
				end
				pmurb_pkg::OFS_CH2_CFG: begin
					nxt_st.rdata[pmurb_pkg::POS_CFG_LO +: pmurb_pkg::CFG_W] = st_ff.cfg[2];
				end
				pmurb_pkg::OFS_CH3_CFG: begin
					nxt_st.rdata[pmurb_pkg::POS_CFG_LO +: pmurb_pkg::CFG_W] = st_ff.cfg[3];
				end
				pmurb_pkg::OFS_SYS_CTRL: begin
					for (int i = 0; i < pmurb_pkg::NUM_CH; i++) begin
						nxt_st.rdata[pmurb_pkg::SYS_CL_LO + i] = st_ff.cfg[i].current_limiter_on;
						nxt_st.rdata[pmurb_pkg::SYS_CPO_LO + i] =
							st_ff.cfg[i].comparator_output_on;
					end
				end
				pmurb_pkg::OFS_READ_SEL: begin
					nxt_st.rdata[pmurb_pkg::SEL_W-1:0] = st_ff.sel;
				end
				pmurb_pkg::OFS_READBACK: begin
					nxt_st.rdata[$bits(pmurb_pkg::pmurb_word_t)-1:0] = word;
				end
				pmurb_pkg::OFS_IRQ_STAT: begin
					nxt_st.rdata[pmurb_pkg::IRQ_W-1:0] = st_ff.irq_stat;
				end
				pmurb_pkg::OFS_IRQ_MASK: begin
					nxt_st.rdata[pmurb_pkg::IRQ_W-1:0] = st_ff.irq_mask;
				end
				default: begin
				end
			endcase
		end

		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
		// open-drain pin pulled low while an alarm is held
		nxt_st.pin_oe = nxt_st.temp_sticky;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_ff <= '0;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// outputs
	assign rdata_o = st_ff.rdata;
	assign irq_o = st_ff.irq;
	assign temp_alarm_pin_oe_o = st_ff.pin_oe;
	assign temp_alarm_pin_o = 1'b0;

endmodule

// ### tb/pmurb_host.sv
// host bus master model that notes expected read data
`timescale 1ns/10ps
module pmurb_host (
	// clock
	input wire logic clk_i,
	// register port
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// ==========
	// bus cycles
	logic [31:0] exq[$];
	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'h0;
		rd_o = 1'h0;
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_o <= w;
		rd_o <= !w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'h0;
		rd_o <= 1'h0;
		// released lines must not keep the last value
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exq.push_back(e);
		acc(1'h0, a, 32'h0);
	endtask
endmodule

// ### tb/pmurb_readback_properties.sv
// concurrent checks on the readback block ports
`timescale 1ns/10ps
module pmurb_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic ce_i,
	input wire logic [pmurb_pkg::ADDR_W-1:0] addr_i,
	input wire logic [pmurb_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [pmurb_pkg::DATA_W-1:0] rdata_o,
	// alarm and interrupt
	input wire logic over_temp_i,
	input wire logic temp_alarm_pin_o,
	input wire logic temp_alarm_pin_oe_o,
	input wire logic irq_o
);
	// ==========
	// properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic rb;
	logic clr;
	assign rb = ce_i && rd_i && addr_i == pmurb_pkg::OFS_READBACK;
	assign clr = ce_i && wr_i && addr_i == pmurb_pkg::OFS_CH0_CFG && wdata_i[6];
	a_rd_idle: assert property (ce_i && !rd_i |=> rdata_o == '0)
		else $error("read data not idle");
	a_sel_zero: assert property (rb |=> rdata_o[31:22] == '0)
		else $error("select bits set");
	a_resv_zero: assert property (rb |=> !rdata_o[18] && rdata_o[4:0] == '0)
		else $error("reserved bits set");
	a_pin_low: assert property (temp_alarm_pin_oe_o |-> !temp_alarm_pin_o)
		else $error("alarm pin not pulled low");
	a_sticky_set: assert property ((ce_i && over_temp_i)[*3] |=> temp_alarm_pin_oe_o)
		else $error("sticky flag late");
	a_rb_sticky: assert property (rb |=> rdata_o[6] == $past(temp_alarm_pin_oe_o))
		else $error("sticky bit differs from pin");
	a_live_read: assert property ((ce_i && over_temp_i)[*3] ##0 rb |=> rdata_o[5])
		else $error("live flag missing");
	a_sticky_clr: assert property ((ce_i && !over_temp_i)[*3] ##0 clr |=> !temp_alarm_pin_oe_o)
		else $error("sticky flag not cleared");
	a_sticky_hold: assert property (temp_alarm_pin_oe_o && ce_i && !wr_i |=> temp_alarm_pin_oe_o)
		else $error("sticky flag lost");
	c_alarm: cover property ($rose(temp_alarm_pin_oe_o));
	c_irq: cover property ($rose(irq_o));
	c_read: cover property (rb);
endmodule
bind pmurb_readback pmurb_chk i_pmurb_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.over_temp_i(over_temp_i), .temp_alarm_pin_o(temp_alarm_pin_o),
	.temp_alarm_pin_oe_o(temp_alarm_pin_oe_o), .irq_o(irq_o));

// ### tb/tb_pmurb_readback.sv
// self-checking bench of the readback block
`timescale 1ns/10ps
module tb_pmurb_readback;
	// ==========
	// bench
	logic clk = 1'h0;
	logic rst;
	logic ce;
	logic ot;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic pin;
	logic oe;
	logic irq;
	logic pend = 1'h0;
	logic [31:0] cfg [4];
	int n_mismatch = 0;
	int num_checks = 0;
	always #4 clk = ~clk;
	pmurb_host i_pmurb_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	pmurb_readback i_pmurb_readback (.clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .over_temp_i(ot),
		.temp_alarm_pin_o(pin), .temp_alarm_pin_oe_o(oe), .irq_o(irq));
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL %s exp %h got %h", nm, e, s);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// read data stands one cycle after the strobe
	always @(posedge clk) pend <= rd & ce;
	always @(negedge clk) if (pend) chk("rdata", rdata, i_pmurb_host.exq.pop_front());
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		logic [31:0] d;
		logic [7:0] s;
		void'($urandom(48996));
		rst = 1'h1;
		ce = 1'h1;
		ot = 1'h0;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		i_pmurb_host.rd(pmurb_pkg::OFS_READBACK, 32'h0);
		// every force and measure code appears once
		for (int c = 0; c < 4; c++) begin
			d = $urandom() & 32'h003B_FF80;
			d[20:19] = 2'(c);
			d[14:13] = 2'(c);
			cfg[c] = d;
			i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_CH0_CFG + 8'(4 * c), d);
		end
		s = 8'($urandom());
		i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_SYS_CTRL, {24'h0, s});
		for (int c = 0; c < 4; c++) begin
			cfg[c][9] = s[c];
			cfg[c][8] = s[4 + c];
			i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_READ_SEL, 32'(c));
			i_pmurb_host.rd(pmurb_pkg::OFS_READBACK, cfg[c]);
		end
		d = cfg[3] ^ 32'h0000_0300;
		i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_CH3_CFG, d);
		i_pmurb_host.rd(pmurb_pkg::OFS_READBACK, d);
		i_pmurb_host.acc(1'h1, 8'h40, $urandom());
		i_pmurb_host.rd(8'h40, 32'h0);
		i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_IRQ_MASK, 32'h1);
		ot <= 1'h1;
		repeat (6) @(posedge clk);
		i_pmurb_host.rd(pmurb_pkg::OFS_READBACK, d | 32'h60);
		@(negedge clk);
		chk("irq", {31'h0, irq}, 32'h1);
		i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_IRQ_STAT, 32'h3);
		@(negedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		ot <= 1'h0;
		repeat (4) @(posedge clk);
		i_pmurb_host.rd(pmurb_pkg::OFS_READBACK, d | 32'h40);
		i_pmurb_host.acc(1'h1, pmurb_pkg::OFS_CH0_CFG, cfg[0] | 32'h40);
		i_pmurb_host.rd(pmurb_pkg::OFS_READBACK, d);
		// clear while the live level is low raises the second status bit
		i_pmurb_host.rd(pmurb_pkg::OFS_IRQ_STAT, 32'h2);
		@(negedge clk);
		chk("oe irq", {30'h0, oe, irq}, 32'h0);
		chk("pin", {31'h0, pin}, 32'h0);
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule
